// ==== core/tx_path_map.svh ====
// register offsets, field positions, reset values and counts for the transmit path
// assumes a 32-bit apb slave on a byte-addressed bus
`ifndef TX_PATH_MAP_SVH
`define TX_PATH_MAP_SVH

`define TXP_CTRL_OFF      12'h000
`define TXP_STATUS_OFF    12'h004

`define TXP_CTRL_ENC_BIT  0
`define TXP_CTRL_HAMP_BIT 1
`define TXP_CTRL_PE_LO    2
`define TXP_CTRL_PE_HI    3
`define TXP_CTRL_FULL_BIT 4
`define TXP_CTRL_SEL_LO   5
`define TXP_CTRL_SEL_HI   6

`define TXP_ENC_RST       1'b1
`define TXP_FULL_RST      1'b1
`define TXP_SEL_RST       2'h0

`define TXP_CHAR_BITS     10
`define TXP_LAST_BIT      4'h9
`define TXP_LATENCY       5
`define TXP_LAST_BYTE     2'h3
`define TXP_AGE_MAX       6'h3f

`endif

// ==== core/tx_path_pkg.sv ====
// types for the transmit mux, encoder and serializer
// assumes tx_path_map.svh sits on the include path
`include "tx_path_map.svh"
package tx_path_pkg;
    typedef logic [`TXP_CHAR_BITS-1:0] lane_t;

    typedef struct packed {
        logic                         enc_en;
        logic                         half_amp;
        logic [1:0]                   preemph;
        logic                         full_rate;
        logic [1:0]                   clk_sel;
        logic                         fclk_q;
        logic [31:0]                  word;
        logic [3:0]                   kflg;
        logic [3:0]                   dforce;
        logic [1:0]                   byte_idx;
        logic [3:0]                   bit_cnt;
        logic                         hold;
        logic                         rd;
        logic [`TXP_LATENCY-1:0][9:0] pipe;
        lane_t                        shift;
        logic                         clk_out;
        logic [31:0]                  prdata;
        logic                         pready;
        logic                         pslverr;
        logic [5:0]                   mode_age;
    } tx_state_s;
endpackage

// ==== core/serdes_tx_path.sv ====
// one channel of the transmit path: 4:1 mux, 8b/10b encoder, 10:1 serializer, apb control
// assumes pclk is the serial bit clock; the byte clock is pclk/10 (pclk/20 at half rate)
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "tx_path_map.svh"

// How it works
// - word 32 bits, two 4-bit flag vectors
// - capture word and flags on fabric rising edge
// - force flag encodes byte from negative disparity
// - flag clear lets encoder balance disparity
// - mux turns 40 bits into 10-bit characters
// - byte clock and quarter-rate fabric clock
// - serializer takes one character per byte clock
// - serial output five byte clocks after input
// - fabric clock returned is byte clock over four
// - select bits choose returned clock source channel
// - lane bits 7..0 byte, bit 8 special
// - lane bit 9 forces negative disparity state
// - bypass sends all ten lane bits raw
// - code bits abcdeifghj map to lane 0..9
// - serializer sends lane bit 0 first
// - config bit selects half amplitude output
// - two-bit preemphasis boost select
// - rate bit sets serializer and byte clock rate
// - encoder picks code by running disparity
// - standard 8b/10b tables including commas
module serdes_tx_path
#(
    parameter logic [1:0] CHAN_ID = 2'h0,
    parameter int         ADDR_W  = 12
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              fabric_tx_clk,
    input  wire logic [31:0]       fabric_tx_word,
    input  wire logic [3:0]        fabric_tx_special_flags,
    input  wire logic [3:0]        fabric_tx_disp_force,
    output logic                   tx_clk_to_fabric,
    output tx_path_pkg::lane_t     serdes_tx_lane,
    output logic                   serial_out,
    output logic                   half_amplitude_en,
    output logic                   preemph_sel_hi,
    output logic                   preemph_sel_lo,
    output logic                   full_rate_mode
);
    import tx_path_pkg::*;

    tx_state_s s;
    tx_state_s n;
    logic      adv;
    logic      tick;
    logic [1:0] sel;
    lane_t     lane_in;
    logic [10:0] enc;
    logic [10:0] neg_enc;
    logic      wr_ok;

    // returns {running disparity after, lane bits}; rd 1 means positive
    function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic k,
                                             input logic rd);
        logic [4:0] x;
        logic [2:0] y;
        logic [5:0] s6;
        logic [3:0] s4;
        logic       rd6;
        logic       k28;
        logic       f4;
        logic [9:0] w;
        logic [9:0] l;
        x   = d[4:0];
        y   = d[7:5];
        k28 = k && (x == 5'h1c);
        case (x)
            5'h00: s6 = 6'b100111;
            5'h01: s6 = 6'b011101;
            5'h02: s6 = 6'b101101;
            5'h03: s6 = 6'b110001;
            5'h04: s6 = 6'b110101;
            5'h05: s6 = 6'b101001;
            5'h06: s6 = 6'b011001;
            5'h07: s6 = 6'b111000;
            5'h08: s6 = 6'b111001;
            5'h09: s6 = 6'b100101;
            5'h0a: s6 = 6'b010101;
            5'h0b: s6 = 6'b110100;
            5'h0c: s6 = 6'b001101;
            5'h0d: s6 = 6'b101100;
            5'h0e: s6 = 6'b011100;
            5'h0f: s6 = 6'b010111;
            5'h10: s6 = 6'b011011;
            5'h11: s6 = 6'b100011;
            5'h12: s6 = 6'b010011;
            5'h13: s6 = 6'b110010;
            5'h14: s6 = 6'b001011;
            5'h15: s6 = 6'b101010;
            5'h16: s6 = 6'b011010;
            5'h17: s6 = 6'b111010;
            5'h18: s6 = 6'b110011;
            5'h19: s6 = 6'b100110;
            5'h1a: s6 = 6'b010110;
            5'h1b: s6 = 6'b110110;
            5'h1c: s6 = 6'b001110;
            5'h1d: s6 = 6'b101110;
            5'h1e: s6 = 6'b011110;
            default: s6 = 6'b101011;
        endcase
        if (k28)
        begin
            s6 = 6'b001111;
        end
        if (rd && (($countones(s6) != 3) || (x == 5'h07)))
        begin
            s6 = ~s6;
        end
        rd6 = rd ^ ($countones(s6) != 3);
        case (y)
            3'h0: s4 = 4'b1011;
            3'h1: s4 = 4'b1001;
            3'h2: s4 = 4'b0101;
            3'h3: s4 = 4'b1100;
            3'h4: s4 = 4'b1101;
            3'h5: s4 = 4'b1010;
            3'h6: s4 = 4'b0110;
            default: s4 = 4'b1110;
        endcase
        // alternate x.7 avoids a run of five inside the code group
        if ((y == 3'h7) && (k || (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
                              || (rd6 && (x == 5'h0b || x == 5'h0d || x == 5'h0e))))
        begin
            s4 = 4'b0111;
        end
        f4 = rd6 && (($countones(s4) != 2) || (y == 3'h3));
        if (k28 && ($countones(s4) == 2) && (y != 3'h3))
        begin
            f4 = !rd6;
        end
        if (f4)
        begin
            s4 = ~s4;
        end
        w = {s6, s4};
        for (int i = 0; i < 10; i++)
        begin
            l[i] = w[9-i];
        end
        return {rd6 ^ ($countones(s4) != 2), l};
    endfunction

    always_comb
    begin
        n       = s;
        adv     = s.full_rate || s.hold;
        tick    = adv && (s.bit_cnt == `TXP_LAST_BIT);
        sel     = `TXP_LAST_BYTE - s.byte_idx;
        lane_in = {s.dforce[sel], s.kflg[sel], s.word[{sel, 3'b000} +: 8]};
        // bit 9 set means start from negative disparity
        enc     = enc8b10b(lane_in[7:0], lane_in[8], lane_in[9] ? 1'b0 : s.rd);
        // same byte encoded from negative disparity, only for the force check
        neg_enc = enc8b10b(lane_in[7:0], lane_in[8], 1'b0);
        wr_ok   = psel && penable && s.pready && pwrite;

        n.fclk_q = fabric_tx_clk;
        if (fabric_tx_clk && !s.fclk_q)
        begin
            n.word   = fabric_tx_word;
            n.kflg   = fabric_tx_special_flags;
            n.dforce = fabric_tx_disp_force;
        end

        n.hold = s.full_rate ? 1'b0 : !s.hold;
        if (adv)
        begin
            n.bit_cnt = tick ? 4'h0 : s.bit_cnt + 4'h1;
            n.shift   = {1'b0, s.shift[9:1]};
        end
        if (tick)
        begin
            n.shift    = s.pipe[`TXP_LATENCY-1];
            n.pipe     = {s.pipe[`TXP_LATENCY-2:0], s.enc_en ? enc[9:0] : lane_in};
            n.byte_idx = s.byte_idx + 2'h1;
            if (s.enc_en)
            begin
                n.rd = enc[10];
            end
        end
        // quarter of the byte clock, high for bytes 0 and 1
        n.clk_out = (s.clk_sel == CHAN_ID) && !n.byte_idx[1];

        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        if (psel && !penable)
        begin
            n.pready = 1'b1;
            n.prdata = 32'h0;
            if (paddr == `TXP_CTRL_OFF)
            begin
                n.prdata[`TXP_CTRL_ENC_BIT]                 = s.enc_en;
                n.prdata[`TXP_CTRL_HAMP_BIT]                = s.half_amp;
                n.prdata[`TXP_CTRL_PE_HI:`TXP_CTRL_PE_LO]   = s.preemph;
                n.prdata[`TXP_CTRL_FULL_BIT]                = s.full_rate;
                n.prdata[`TXP_CTRL_SEL_HI:`TXP_CTRL_SEL_LO] = s.clk_sel;
            end
            else if (paddr == `TXP_STATUS_OFF)
            begin
                n.prdata[2:0] = {s.byte_idx, s.rd};
            end
            else
            begin
                n.pslverr = 1'b1;
            end
        end
        if (wr_ok && (paddr == `TXP_CTRL_OFF))
        begin
            n.enc_en    = pwdata[`TXP_CTRL_ENC_BIT];
            n.half_amp  = pwdata[`TXP_CTRL_HAMP_BIT];
            n.preemph   = pwdata[`TXP_CTRL_PE_HI:`TXP_CTRL_PE_LO];
            n.full_rate = pwdata[`TXP_CTRL_FULL_BIT];
            n.clk_sel   = pwdata[`TXP_CTRL_SEL_HI:`TXP_CTRL_SEL_LO];
            n.mode_age  = 6'h0;
        end
        else if (s.mode_age != `TXP_AGE_MAX)
        begin
            n.mode_age = s.mode_age + 6'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s           <= '0;
            s.enc_en    <= `TXP_ENC_RST;
            s.full_rate <= `TXP_FULL_RST;
            s.clk_sel   <= `TXP_SEL_RST;
        end
        else
        begin
            s <= n;
        end
    end

    assign prdata            = s.prdata;
    assign pready            = s.pready;
    assign pslverr           = s.pslverr;
    assign tx_clk_to_fabric  = s.clk_out;
    assign serdes_tx_lane    = s.pipe[0];
    assign serial_out        = s.shift[0];
    assign half_amplitude_en = s.half_amp;
    assign preemph_sel_hi    = s.preemph[1];
    assign preemph_sel_lo    = s.preemph[0];
    assign full_rate_mode    = s.full_rate;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_capture;
        (fabric_tx_clk && !s.fclk_q) |=> (s.word == $past(fabric_tx_word))
                                         && (s.kflg == $past(fabric_tx_special_flags))
                                         && (s.dforce == $past(fabric_tx_disp_force));
    endproperty
    a_capture: assert property (p_capture) else $error("fabric word not captured");

    property p_force;
        (tick && s.enc_en && lane_in[9]) |=>
            ((s.pipe[0] == $past(neg_enc[9:0]))
             && ($countones(s.pipe[0]) >= 5));
    endproperty
    a_force: assert property (p_force) else $error("forced byte not from negative rd");

    property p_bypass;
        (tick && !s.enc_en) |=> ((s.pipe[0] == $past(lane_in))
                                 && $stable(s.rd));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass altered the lane");

    property p_latency;
        (tick && s.full_rate) |-> ##51 ((s.mode_age < 6'h34) || (s.shift == $past(s.pipe[0], 50)));
    endproperty
    a_latency: assert property (p_latency) else $error("serial latency not five bytes");

    property p_lsb_first;
        (adv && !tick) |=> (s.shift == {1'b0, $past(s.shift[9:1])});
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("serializer order wrong");

    property p_clk_div;
        ($rose(tx_clk_to_fabric) && ($past(s.clk_sel) == $past(s.clk_sel, 2)))
            |-> (s.byte_idx == 2'h0);
    endproperty
    a_clk_div: assert property (p_clk_div) else $error("returned clock misphased");

    sequence s_not_selected;
        (s.clk_sel != CHAN_ID) [*2];
    endsequence
    property p_clk_sel;
        s_not_selected |-> !tx_clk_to_fabric;
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("unselected channel drives clock");

    property p_preemph;
        (wr_ok && (paddr == `TXP_CTRL_OFF)) |=>
            ({preemph_sel_hi, preemph_sel_lo} == $past(pwdata[`TXP_CTRL_PE_HI:`TXP_CTRL_PE_LO]));
    endproperty
    a_preemph: assert property (p_preemph) else $error("preemphasis not written");

    property p_byte_order;
        tick |=> (s.byte_idx == $past(s.byte_idx) + 2'h1);
    endproperty
    a_byte_order: assert property (p_byte_order) else $error("mux byte order broken");

    // byte 0 of every word is the top byte with flag bit 3
    property p_byte_map;
        (tick && (s.byte_idx == 2'h0)) |->
            (lane_in == {s.dforce[3], s.kflg[3], s.word[31:24]});
    endproperty
    a_byte_map: assert property (p_byte_map) else $error("byte 0 misrouted");

    property p_shift_load;
        tick |=> (s.shift == $past(s.pipe[`TXP_LATENCY-1]));
    endproperty
    a_shift_load: assert property (p_shift_load) else $error("shifter load missed");

    property p_rd_track;
        (tick && s.enc_en && !lane_in[9]) |=>
            (s.rd == ($past(s.rd) ^ ($countones(s.pipe[0]) != 5)));
    endproperty
    a_rd_track: assert property (p_rd_track) else $error("disparity not tracked");

    // an unforced code may only push the running disparity back toward neutral
    property p_free_balance;
        (tick && s.enc_en && !lane_in[9]) |=>
            (($countones(s.pipe[0]) == 5) || ($past(s.rd) != ($countones(s.pipe[0]) > 5)));
    endproperty
    a_free_balance: assert property (p_free_balance) else $error("disparity grew");

    property p_comma;
        (tick && s.enc_en && lane_in[8] && (lane_in[7:0] == 8'hbc)) |=>
            ((s.pipe[0] == 10'h17c) || (s.pipe[0] == 10'h283));
    endproperty
    a_comma: assert property (p_comma) else $error("comma code wrong");

    property p_half_amp;
        (wr_ok && (paddr == `TXP_CTRL_OFF)) |=>
            (half_amplitude_en == $past(pwdata[`TXP_CTRL_HAMP_BIT]));
    endproperty
    a_half_amp: assert property (p_half_amp) else $error("half amplitude lost");

    property p_full_rate;
        (wr_ok && (paddr == `TXP_CTRL_OFF)) |=>
            (full_rate_mode == $past(pwdata[`TXP_CTRL_FULL_BIT]));
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("rate bit not written");

    // half rate: every other cycle the serializer holds its bit
    sequence s_half_rate_idle;
        !s.full_rate && !s.hold;
    endsequence
    property p_half_hold;
        s_half_rate_idle |=> ($stable(s.bit_cnt) && $stable(s.shift));
    endproperty
    a_half_hold: assert property (p_half_hold) else $error("half rate bit moved");

    // the returned clock is still low one cycle after reset, so that sample is skipped
    property p_clk_phase;
        ($past(presetn) && ($past(s.clk_sel) == CHAN_ID)) |->
            (tx_clk_to_fabric == !s.byte_idx[1]);
    endproperty
    a_clk_phase: assert property (p_clk_phase) else $error("clock duty wrong");
endmodule

// ==== testbench/fabric_src.sv ====
// fabric user logic model: hands one flagged word per returned transmit clock
// assumes clk_in is the returned clock and the bench refreshes next_word on taken
`timescale 1ns/1ps
module fabric_src
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_in,
    input  wire logic [39:0] next_word,
    output logic             fclk,
    output logic [31:0]      word,
    output logic [3:0]       kflg,
    output logic [3:0]       dforce,
    output logic             taken
);
    // data moves on the falling half so it is settled long before the rising edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fclk   <= 1'b0;
            word   <= 32'h0;
            kflg   <= 4'h0;
            dforce <= 4'h0;
            taken  <= 1'b0;
        end
        else
        begin
            fclk  <= clk_in;
            taken <= fclk & ~clk_in;
            if (fclk & ~clk_in)
            begin
                {dforce, kflg, word} <= next_word;
            end
        end
    end
endmodule

// ==== testbench/serdes_tx_path_test.sv ====
// self-checking bench for one transmit channel: apb control, encoder, serializer
// assumes the fabric model runs off the returned clock of channel 0
`timescale 1ns/1ps
`include "tx_path_map.svh"
module serdes_tx_path_test;
    import tx_path_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, h;
    logic        fclk, taken, rnd_on, ret_clk, ser, half, pe_hi, pe_lo, full;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, fword;
    logic [3:0]  fk, fd;
    logic [39:0] nw;
    lane_t       lane, chr;
    lane_t       ln [0:399];
    logic        sb [0:399];
    int          err_total, cmp_count, cyc, n, p;

    serdes_tx_path uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fabric_tx_clk(fclk), .fabric_tx_word(fword),
        .fabric_tx_special_flags(fk), .fabric_tx_disp_force(fd), .tx_clk_to_fabric(ret_clk),
        .serdes_tx_lane(lane), .serial_out(ser), .half_amplitude_en(half),
        .preemph_sel_hi(pe_hi), .preemph_sel_lo(pe_lo), .full_rate_mode(full));
    fabric_src fab (.pclk(pclk), .presetn(presetn), .clk_in(ret_clk), .next_word(nw),
        .fclk(fclk), .word(fword), .kflg(fk), .dforce(fd), .taken(taken));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // entered just after a rising or falling edge; only the global cycle limit ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // pclk cycles between two rising edges of the returned clock
    task automatic period(output int pr);
        logic old;
        pr = 0;
        for (int r = 0; r < 2; r++)
        begin
            do
            begin
                old = ret_clk;
                @(negedge pclk);
                pr++;
            end
            while (!(old === 1'b0 && ret_clk === 1'b1) && pr < 400);
            if (r == 0) pr = 0;
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        if (rnd_on && taken) nw <= {8'($urandom), 32'($urandom)};
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            conclude();
        end
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        nw = 40'h0;
        rnd_on = 1'b0;
        void'($urandom(63));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `TXP_STATUS_OFF, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, `TXP_CTRL_OFF, 32'h0);
        chk(q, 32'h11);
        chk({31'h0, full}, 32'h1);
        $display("test reset done");
        for (int pe = 0; pe < 4; pe++)
        begin
            h = 1'($urandom);
            apb(1'b1, `TXP_CTRL_OFF, 32'h11 | (pe << 2) | (32'(h) << 1));
            chk({28'h0, half, pe_hi, pe_lo, full}, {28'h0, h, 2'(pe), 1'b1});
            apb(1'b0, `TXP_CTRL_OFF, 32'h0);
            chk(q, 32'h11 | (pe << 2) | (32'(h) << 1));
        end
        apb(1'b1, 12'h00c, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        apb(1'b0, `TXP_CTRL_OFF, 32'h0);
        chk(q, 32'h1d | (32'(h) << 1));
        $display("test control done");
        // k28.5 with every byte forced: always the negative-disparity code
        apb(1'b1, `TXP_CTRL_OFF, 32'h11);
        nw <= {4'hf, 4'hf, 32'hbcbcbcbc};
        repeat (120) @(negedge pclk);
        for (int i = 0; i < 41; i++)
        begin
            @(negedge pclk);
            chk(32'(lane), 32'h17c);
        end
        nw <= {4'h0, 4'hf, 32'hbcbcbcbc};
        repeat (120) @(negedge pclk);
        n = 0;
        // 40 cycles hold exactly four byte ticks whatever the phase
        for (int i = 0; i < 40; i++)
        begin
            ln[0] = lane;
            @(negedge pclk);
            n += int'(lane !== ln[0]);
            chk(32'(lane == 10'h17c || lane == 10'h283), 32'h1);
        end
        chk(n, 4);
        $display("test encoder done");
        apb(1'b1, `TXP_CTRL_OFF, 32'h10);
        rnd_on = 1'b1;
        repeat (100) @(negedge pclk);
        for (int i = 0; i < 400; i++)
        begin
            @(negedge pclk);
            ln[i] = lane;
            sb[i] = ser;
        end
        // a lane change marks the tick; its bits show 50 samples later, bit 0 first
        for (int i = 1; i < 330; i++)
        begin
            if (ln[i] !== ln[i-1])
            begin
                for (int b = 0; b < 10; b++) chr[b] = sb[i+50+b];
                chk(32'(chr), 32'(ln[i]));
            end
        end
        rnd_on = 1'b0;
        $display("test bypass done");
        period(p);
        chk(p, 40);
        apb(1'b1, `TXP_CTRL_OFF, 32'h01);
        period(p);
        period(p);
        chk(p, 80);
        chk({31'h0, full}, 32'h0);
        apb(1'b1, `TXP_CTRL_OFF, 32'h31);
        n = 0;
        repeat (200) @(negedge pclk) n += int'(ret_clk !== 1'b0);
        chk(n, 0);
        $display("test clocks done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `TXP_STATUS_OFF, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, `TXP_CTRL_OFF, 32'h0);
        chk(q, 32'h11);
        chk({31'h0, full}, 32'h1);
        $display("test mid-run reset done");
        conclude();
    end

    initial
    begin
        err_total = 0;
        cmp_count = 0;
        cyc = 0;
    end
endmodule
